/* File: common/eip_pkg.sv */
// Constants, modes and carrier types for the external pin interrupt block
package eip_pkg;
  // Widths
  localparam int NPIN   = 8;
  localparam int NLOW   = 4;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int EVT_W  = 2;

  // Register indices on the plain register port
  localparam logic [2:0] REG_SENSE_LOW  = 3'h0;
  localparam logic [2:0] REG_SENSE_HIGH = 3'h1;
  localparam logic [2:0] REG_MASK       = 3'h2;
  localparam logic [2:0] REG_FLAG       = 3'h3;
  localparam logic [2:0] REG_EVT_STAT   = 3'h4;
  localparam logic [2:0] REG_EVT_MASK   = 3'h5;
  localparam logic [2:0] REG_PIN_STATE  = 3'h6;

  // Reset values
  localparam logic [7:0] SENSE_RST = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [7:0] ZERO8     = 8'h00;

  // Event status bit positions
  localparam int EVT_WAKE       = 0;
  localparam int EVT_WAKE_NOIRQ = 1;

  // Sense select encodings (hi bit, lo bit)
  localparam logic [1:0] SENSE_LEVEL_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY       = 2'h1;
  localparam logic [1:0] SENSE_FALL      = 2'h2;
  localparam logic [1:0] SENSE_RISE      = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int WDT_PERIOD_NS   = 1000;
  localparam int WDT_CYCLES      = WDT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int STARTUP_TIME_US = 64;
  localparam int STARTUP_CYCLES  = (STARTUP_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int WDT_CNT_W       = 5;
  localparam int SUT_CNT_W       = 11;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } eip_bus_type;

  // Wake-up events
  typedef struct packed {
    logic wake;
    logic lost;
  } eip_wake_type;
endpackage

/* File: sim/eip_pin_src.sv */
// Model of the external circuitry driving the interrupt pins
`timescale 1ns/1ps
module eip_pin_src (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Requested levels and driven pads
  input  wire logic [7:0] tgt,
  output logic      [7:0] pins
);
  // Pads idle high as with pull-ups; a level is held until the bench changes it,
  // so a low level lasts until the bench releases it, which the wake test does during start-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins <= 8'hFF;
    end else begin
      pins <= tgt;
    end
  end
endmodule

/* File: sim/eip_top_chk.sv */
// Port-level assertions for the external pin interrupt block
`timescale 1ns/1ps
module eip_top_chk (
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       RST_N,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Pins and core status
  input wire logic [7:0] EXT_IRQ_PIN,
  input wire logic       CORE_I_FLAG,
  input wire logic       IO_CLK_RUN,
  input wire logic       SLEEP_PWRDN,
  input wire logic       COMPAT_MODE,
  // Requests and wake
  input wire logic [7:0] IRQ_REQ,
  input wire logic [7:0] IRQ_ACK,
  input wire logic       WAKE_REQ,
  input wire logic       IRQ
);
  logic [7:0]  mask_r;
  logic [7:0]  sense_lo_r;
  logic [7:0]  sense_hi_r;
  logic [7:0]  lvl_old_r;
  logic [10:0] quiet_r;
  wire  [7:0]  lvl_sel;
  wire  [15:0] sense_all = {sense_hi_r, sense_lo_r};
  wire         flag_wr   = WR && ADDR == eip_pkg::REG_FLAG;
  wire         fall_on   = mask_r[0] && sense_lo_r[1:0] == eip_pkg::SENSE_FALL && CORE_I_FLAG;
  wire         fall_en   = fall_on && !IRQ_ACK[0] && !flag_wr;
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // Shadow control registers; quiet counter keeps level checks clear of wake start-up
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mask_r     <= 8'h00;
      sense_lo_r <= 8'h00;
      sense_hi_r <= 8'h00;
      lvl_old_r  <= 8'hFF;
      // Starts saturated: no wake start-up can be running straight out of reset
      quiet_r    <= 11'h7FF;
    end else begin
      if (WR && ADDR == eip_pkg::REG_MASK) mask_r <= WDATA;
      if (WR && ADDR == eip_pkg::REG_SENSE_LOW && !COMPAT_MODE) sense_lo_r <= WDATA;
      if (WR && ADDR == eip_pkg::REG_SENSE_HIGH) sense_hi_r <= WDATA;
      lvl_old_r <= lvl_sel;
      quiet_r   <= SLEEP_PWRDN ? 11'h000 : (quiet_r == 11'h7FF ? quiet_r : quiet_r + 11'h001);
    end
  end

  // Per-pin level mode and held-low request
  for (genvar i = 0; i < 8; i++) begin : g_pin
    wire lvl_on = mask_r[i] && lvl_sel[i] && CORE_I_FLAG && quiet_r == 11'h7FF;
    assign lvl_sel[i] = sense_all[2*i+1 -: 2] == eip_pkg::SENSE_LEVEL_LOW;
    AST_LEVEL: assert property ((lvl_on && !EXT_IRQ_PIN[i]) [*5] |-> IRQ_REQ[i])
      else $error("level request missing on a held low pin");
  end

  AST_NO_GLOBAL: assert property (!CORE_I_FLAG [*3] |-> IRQ_REQ == 8'h00)
    else $error("request without global enable");
  AST_NO_MASK: assert property ((IRQ_REQ & ~(mask_r | $past(mask_r) | $past(mask_r, 2))) == 8'h00)
    else $error("request on a masked pin");
  AST_FALL0: assert property ((fall_en && EXT_IRQ_PIN[0]) ##1 (fall_en && !EXT_IRQ_PIN[0]) [*5]
    |-> IRQ_REQ[0]) else $error("falling edge on pin 0 not requested");
  AST_ACK_CLR: assert property ((EXT_IRQ_PIN[0] && sense_lo_r[1:0] == eip_pkg::SENSE_FALL) [*4]
    ##0 IRQ_ACK[0] |-> ##2 !IRQ_REQ[0]) else $error("acknowledge left request standing");
  AST_RSVD: assert property ((sense_lo_r[1:0] == 2'h1) [*4] |-> !IRQ_REQ[0])
    else $error("reserved sense code raised a request");
  AST_COMPAT: assert property (RD && ADDR == eip_pkg::REG_SENSE_LOW && COMPAT_MODE |=> RDATA == 8'h00)
    else $error("low sense register visible in legacy mode");
  AST_FLAG_LVL: assert property (RD && ADDR == eip_pkg::REG_FLAG |=>
    (RDATA & $past(lvl_sel & lvl_old_r)) == 8'h00) else $error("level pin flag read as set");
  AST_WAKE_IDLE: assert property (!SLEEP_PWRDN [*4] |-> !WAKE_REQ)
    else $error("wake request outside power-down");
endmodule

bind eip_top eip_top_chk u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .EXT_IRQ_PIN(EXT_IRQ_PIN), .CORE_I_FLAG(CORE_I_FLAG), .IO_CLK_RUN(IO_CLK_RUN),
  .SLEEP_PWRDN(SLEEP_PWRDN), .COMPAT_MODE(COMPAT_MODE), .IRQ_REQ(IRQ_REQ), .IRQ_ACK(IRQ_ACK),
  .WAKE_REQ(WAKE_REQ), .IRQ(IRQ)
);

/* File: sim/eip_top_tb.sv */
// Self-checking testbench for the external pin interrupt block
`timescale 1ns/1ps
module eip_top_tb;
  logic       clock = 1'b0;
  logic       rst_n, wr, rd, i_flag, io_run, sleep, compat, rsv, ef, er;
  logic [2:0] addr;
  logic [7:0] wdata, ack, pin_tgt, b;
  wire  [7:0] rdata, irq_req, pins;
  wire        wake_req, irq;
  int         failures, comparisons, n;

  // 25 MHz core clock
  always #20 clock = ~clock;

  eip_pin_src u_src (.clk(clock), .rst_n(rst_n), .tgt(pin_tgt), .pins(pins));
  eip_top u_dut (
    .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .EXT_IRQ_PIN(pins), .CORE_I_FLAG(i_flag), .IO_CLK_RUN(io_run), .SLEEP_PWRDN(sleep),
    .COMPAT_MODE(compat), .IRQ_REQ(irq_req), .IRQ_ACK(ack), .WAKE_REQ(wake_req), .IRQ(irq)
  );

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Register port cycles: one strobe cycle each, read data the cycle after
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    chk(rdata, exp);
  endtask

  // Long enough for the two sync stages and the request register
  task automatic settle();
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic drive(input int p, input logic v);
    @(posedge clock);
    pin_tgt[p] <= v;
  endtask

  initial begin
    {rst_n, wr, rd, io_run, sleep, compat} = 6'h00;
    addr        = 3'h0;
    wdata       = 8'h00;
    ack         = 8'h00;
    pin_tgt     = 8'hFF;
    i_flag      = 1'b1;
    failures    = 0;
    comparisons = 0;
    repeat (12) @(posedge clock);
    rst_n  <= 1'b1;
    io_run <= 1'b1;
    compat <= 1'b1;
    // Legacy mode hides the low sense register; unmapped index reads zero
    wr_reg(eip_pkg::REG_SENSE_LOW, 8'hFF);
    rd_chk(eip_pkg::REG_SENSE_LOW, 8'h00);
    @(posedge clock);
    compat <= 1'b0;
    rd_chk(eip_pkg::REG_SENSE_LOW, 8'h00);
    wr_reg(3'h7, 8'hFF);
    rd_chk(3'h7, 8'h00);
    // Every sense code on a low and a high pin, reconfigured in the safe order
    for (int p = 0; p < 8; p += 4) begin
      for (int m = 0; m < 4; m++) begin
        b   = 8'h01 << p;
        rsv = (p == 0 && m == 1);
        ef  = !rsv && m != 3;
        er  = (m == 1 && !rsv) || m >= 2;
        wr_reg(eip_pkg::REG_MASK, 8'h00);
        wr_reg(p == 0 ? eip_pkg::REG_SENSE_LOW : eip_pkg::REG_SENSE_HIGH, 8'(m));
        wr_reg(eip_pkg::REG_FLAG, 8'hFF);
        wr_reg(eip_pkg::REG_MASK, b);
        drive(p, 1'b0);
        settle();
        chk(irq_req & b, ef ? b : 8'h00);
        drive(p, 1'b1);
        settle();
        chk(irq_req & b, er ? b : 8'h00);
        if (!rsv) rd_chk(eip_pkg::REG_FLAG, er ? b : 8'h00);
        wr_reg(eip_pkg::REG_FLAG, 8'h00);
        settle();
        chk(irq_req & b, er ? b : 8'h00);
        wr_reg(eip_pkg::REG_FLAG, b);
        settle();
        chk(irq_req & b, 8'h00);
      end
    end
    // Acknowledge clears a pending falling-edge request
    wr_reg(eip_pkg::REG_SENSE_LOW, 8'h02);
    wr_reg(eip_pkg::REG_FLAG, 8'hFF);
    wr_reg(eip_pkg::REG_MASK, 8'h01);
    drive(0, 1'b0);
    drive(0, 1'b1);
    settle();
    chk(irq_req, 8'h01);
    @(posedge clock);
    ack <= 8'h01;
    @(posedge clock);
    ack <= 8'h00;
    settle();
    chk(irq_req, 8'h00);
    // Global enable gates a held low level
    wr_reg(eip_pkg::REG_MASK, 8'h00);
    wr_reg(eip_pkg::REG_SENSE_LOW, 8'h00);
    wr_reg(eip_pkg::REG_MASK, 8'h01);
    i_flag <= 1'b0;
    drive(0, 1'b0);
    settle();
    chk(irq_req, 8'h00);
    @(posedge clock);
    i_flag <= 1'b1;
    settle();
    chk(irq_req, 8'h01);
    settle();
    chk(irq_req, 8'h01);
    drive(0, 1'b1);
    // Stopped I/O clock: low pin edge still seen, high pin edge waits
    wr_reg(eip_pkg::REG_MASK, 8'h00);
    wr_reg(eip_pkg::REG_SENSE_LOW, 8'h02);
    wr_reg(eip_pkg::REG_SENSE_HIGH, 8'h02);
    wr_reg(eip_pkg::REG_FLAG, 8'hFF);
    wr_reg(eip_pkg::REG_MASK, 8'h11);
    io_run <= 1'b0;
    pin_tgt <= 8'hEE;
    settle();
    chk(irq_req, 8'h01);
    @(posedge clock);
    io_run <= 1'b1;
    settle();
    chk(irq_req, 8'h11);
    @(posedge clock);
    pin_tgt <= 8'hFF;
    // Level wake from power-down; the level vanishes during start-up
    wr_reg(eip_pkg::REG_MASK, 8'h00);
    wr_reg(eip_pkg::REG_SENSE_LOW, 8'h00);
    wr_reg(eip_pkg::REG_FLAG, 8'hFF);
    wr_reg(eip_pkg::REG_MASK, 8'h01);
    wr_reg(eip_pkg::REG_EVT_MASK, 8'h03);
    sleep <= 1'b1;
    drive(0, 1'b0);
    n = 0;
    while (wake_req !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (wake_req !== 1'b1) begin
      failures++;
      give_verdict();
    end
    chk({7'h00, wake_req}, 8'h01);
    drive(0, 1'b1);
    sleep <= 1'b0;
    settle();
    chk({7'h00, irq}, 8'h01);
    repeat (1700) @(posedge clock);
    rd_chk(eip_pkg::REG_EVT_STAT, 8'h03);
    wr_reg(eip_pkg::REG_EVT_MASK, 8'h00);
    settle();
    chk({7'h00, irq}, 8'h00);
    wr_reg(eip_pkg::REG_EVT_MASK, 8'h03);
    settle();
    chk({7'h00, irq}, 8'h01);
    wr_reg(eip_pkg::REG_EVT_STAT, 8'h03);
    settle();
    chk({7'h00, irq}, 8'h00);
    give_verdict();
  end
endmodule

/* File: verilog/eip_sync.sv */
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module eip_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* File: verilog/eip_top.sv */
// External pin interrupt controller: sense, flags, masks, wake-up and registers
//
// Contract
// - Pin activity requests an interrupt even when the pin drives as output.
// - Low pins: 00 low level, 01 reserved, 10 falling, 11 rising edge.
// - Enabled low-level sensing requests continuously while the pin stays low.
// - High-pin edges are only recognised while the I/O clock runs.
// - Low levels and low-pin edges are detected with the I/O clock stopped.
// - Level wake from power-down samples the level twice at watchdog rate.
// - Wake when level passes both samples or holds to start-up end.
// - Level gone before start-up end: core wakes, no interrupt issued.
// - Low sense register resets to low level; blocked in legacy mode.
// - A request needs the global enable and the pin mask bit set.
// - Changing sense while enabled may give a spurious request.
// - Writing one clears a flag; writing zero leaves it.
// - High pins: 00 low level, 01 any change, 10 falling, 11 rising.
// - Edge or change sets the flag; vector acknowledge clears it.
// - Flags of level-sensed pins always read as cleared.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
module eip_top (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  // Register port
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Pins and core status
  input  wire logic [7:0] EXT_IRQ_PIN,
  input  wire logic       CORE_I_FLAG,
  input  wire logic       IO_CLK_RUN,
  input  wire logic       SLEEP_PWRDN,
  input  wire logic       COMPAT_MODE,
  // Requests to the priority logic and their acknowledge
  output logic      [7:0] IRQ_REQ,
  input  wire logic [7:0] IRQ_ACK,
  // Wake-up and event interrupt
  output logic            WAKE_REQ,
  output logic            IRQ
);
  // Register port request bundle
  eip_pkg::eip_bus_type bus;
  assign bus.addr  = ADDR;
  assign bus.wdata = WDATA;
  assign bus.wr    = WR;
  assign bus.rd    = RD;

  // Sense select decode: true if this pin has an edge event this cycle
  function automatic logic edge_hit(input logic [1:0] mode, input logic cur,
                                    input logic prev, input logic high);
    logic hit;
    hit = 1'b0;
    case (mode)
      eip_pkg::SENSE_ANY:  hit = high && (cur != prev); // reserved on low pins
      eip_pkg::SENSE_FALL: hit = prev && !cur;
      eip_pkg::SENSE_RISE: hit = !prev && cur;
      default:             hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Field select from the two sense registers
  function automatic logic [1:0] sense_of(input logic [15:0] sense, input int n);
    logic [1:0] m;
    m = sense[2*n +: 2];
    return m;
  endfunction

  // Registers
  logic [7:0]                 sense_ctrl_low_r;
  logic [7:0]                 sense_ctrl_high_r;
  logic [7:0]                 ext_irq_mask_reg_r;
  logic [7:0]                 ext_irq_flag_r;
  logic [7:0]                 ext_irq_flag_nxt;
  logic [7:0]                 pin_prev_r;
  logic [7:0]                 pin_prev_nxt;
  logic [eip_pkg::EVT_W-1:0]  evt_stat_r;
  logic [eip_pkg::EVT_W-1:0]  evt_stat_nxt;
  logic [eip_pkg::EVT_W-1:0]  evt_mask_r;
  logic [7:0]                 rdata_nxt;
  logic [7:0]                 irq_req_nxt;

  // Internal wires
  logic [7:0]                 pin_s;
  logic [15:0]                sense_all;
  logic [7:0]                 is_level;
  logic [7:0]                 edge_set;
  logic [7:0]                 level_req;
  logic                       level_wake_hit;
  logic                       starting;
  eip_pkg::eip_wake_type      wake_evt;

  // Pin levels into the clock domain; the pad is read whatever its direction
  eip_sync #(
    .W (eip_pkg::NPIN)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .d     (EXT_IRQ_PIN),
    .q     (pin_s)
  );

  // Level wake-up qualifier for power-down
  eip_wake u_wake (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .sleep     (SLEEP_PWRDN),
    .level_hit (level_wake_hit),
    .starting  (starting),
    .evt       (wake_evt)
  );

  // Write decode; the low sense register is closed in legacy mode
  wire wr_sense_low  = bus.wr && (bus.addr == eip_pkg::REG_SENSE_LOW) && !COMPAT_MODE;
  wire wr_sense_high = bus.wr && (bus.addr == eip_pkg::REG_SENSE_HIGH);
  wire wr_mask       = bus.wr && (bus.addr == eip_pkg::REG_MASK);
  wire wr_flag       = bus.wr && (bus.addr == eip_pkg::REG_FLAG);
  wire wr_evt_stat   = bus.wr && (bus.addr == eip_pkg::REG_EVT_STAT);
  wire wr_evt_mask   = bus.wr && (bus.addr == eip_pkg::REG_EVT_MASK);

  assign sense_all = {sense_ctrl_high_r, sense_ctrl_low_r};

  // Per-pin sensing, flags and requests
  always_comb begin
    pin_prev_nxt     = pin_prev_r;
    ext_irq_flag_nxt = ext_irq_flag_r;
    is_level         = '0;
    edge_set         = '0;
    level_req        = '0;
    for (int n = 0; n < eip_pkg::NPIN; n++) begin
      is_level[n] = (sense_of(sense_all, n) == eip_pkg::SENSE_LEVEL_LOW);
      if (n < eip_pkg::NLOW) begin
        // Low pins need no I/O clock for edges
        pin_prev_nxt[n] = pin_s[n];
        edge_set[n]     = edge_hit(sense_of(sense_all, n), pin_s[n], pin_prev_r[n], 1'b0);
      end else if (IO_CLK_RUN) begin
        // High pins sample only while the I/O clock runs
        pin_prev_nxt[n] = pin_s[n];
        edge_set[n]     = edge_hit(sense_of(sense_all, n), pin_s[n], pin_prev_r[n], 1'b1);
      end
      // Level request holds as long as the pin is low
      level_req[n] = is_level[n] && !pin_s[n];
      // Clear by one-write or by acknowledge, but a new edge wins
      if ((wr_flag && bus.wdata[n]) || IRQ_ACK[n]) ext_irq_flag_nxt[n] = 1'b0;
      if (edge_set[n]) ext_irq_flag_nxt[n] = 1'b1;
      // Level-sensed pins keep no flag
      if (is_level[n]) ext_irq_flag_nxt[n] = 1'b0;
    end
  end

  // Any enabled low-level pin can start a power-down wake
  assign level_wake_hit = |(level_req & ext_irq_mask_reg_r);

  // Requests need global enable and mask; a sense change while enabled may
  // fire a spurious edge, as the old sample is compared under the new mode
  // Level requests pause during start-up so a lost level yields none
  assign irq_req_nxt = CORE_I_FLAG ? (ext_irq_mask_reg_r &
                       ((ext_irq_flag_nxt & ~is_level) | (level_req & {8{!starting}}))) : '0;

  // Event status: set wins over a write-one clear
  always_comb begin
    evt_stat_nxt = evt_stat_r;
    if (wr_evt_stat) evt_stat_nxt = evt_stat_r & ~bus.wdata[eip_pkg::EVT_W-1:0];
    if (wake_evt.wake) evt_stat_nxt[eip_pkg::EVT_WAKE] = 1'b1;
    if (wake_evt.lost) evt_stat_nxt[eip_pkg::EVT_WAKE_NOIRQ] = 1'b1;
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    rdata_nxt = eip_pkg::ZERO8;
    if (bus.rd) begin
      case (bus.addr)
        eip_pkg::REG_SENSE_LOW:  rdata_nxt = COMPAT_MODE ? eip_pkg::ZERO8 : sense_ctrl_low_r;
        eip_pkg::REG_SENSE_HIGH: rdata_nxt = sense_ctrl_high_r;
        eip_pkg::REG_MASK:       rdata_nxt = ext_irq_mask_reg_r;
        eip_pkg::REG_FLAG:       rdata_nxt = ext_irq_flag_r & ~is_level;
        eip_pkg::REG_EVT_STAT:   rdata_nxt = {6'h00, evt_stat_r};
        eip_pkg::REG_EVT_MASK:   rdata_nxt = {6'h00, evt_mask_r};
        eip_pkg::REG_PIN_STATE:  rdata_nxt = pin_s;
        default:                 rdata_nxt = eip_pkg::ZERO8;
      endcase
    end
  end

  // Configuration registers; low sense resets to low level on every pin
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sense_ctrl_low_r   <= eip_pkg::SENSE_RST;
      sense_ctrl_high_r  <= eip_pkg::SENSE_RST;
      ext_irq_mask_reg_r <= eip_pkg::MASK_RST;
      evt_mask_r         <= '0;
    end else begin
      if (wr_sense_low)  sense_ctrl_low_r   <= bus.wdata;
      if (wr_sense_high) sense_ctrl_high_r  <= bus.wdata;
      if (wr_mask)       ext_irq_mask_reg_r <= bus.wdata;
      if (wr_evt_mask)   evt_mask_r         <= bus.wdata[eip_pkg::EVT_W-1:0];
    end
  end

  // Detection state and status
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pin_prev_r     <= '1;
      ext_irq_flag_r <= '0;
      evt_stat_r     <= '0;
    end else begin
      pin_prev_r     <= pin_prev_nxt;
      ext_irq_flag_r <= ext_irq_flag_nxt;
      evt_stat_r     <= evt_stat_nxt;
    end
  end

  // Registered outputs; wake also follows enabled low-pin edge flags
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA    <= '0;
      IRQ_REQ  <= '0;
      WAKE_REQ <= 1'b0;
      IRQ      <= 1'b0;
    end else begin
      RDATA    <= rdata_nxt;
      IRQ_REQ  <= irq_req_nxt;
      WAKE_REQ <= wake_evt.wake ||
                  (SLEEP_PWRDN && |(ext_irq_flag_nxt[eip_pkg::NLOW-1:0] & ext_irq_mask_reg_r[eip_pkg::NLOW-1:0]));
      IRQ      <= |(evt_stat_nxt & evt_mask_r);
    end
  end
endmodule

/* File: verilog/eip_wake.sv */
// Level wake-up qualifier: watchdog-rate double sample and start-up timer
`timescale 1ns/1ps
module eip_wake (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Core state and qualified level
  input  wire logic                  sleep,
  input  wire logic                  level_hit,
  // Results
  output logic                       starting,
  output eip_pkg::eip_wake_type      evt
);
  typedef enum logic [1:0] {W_IDLE, W_SAMPLE1, W_START} eip_wstate_type;

  localparam logic [4:0]  WDT_LAST = 5'(eip_pkg::WDT_CYCLES - 1);
  localparam logic [10:0] SUT_LAST = 11'(eip_pkg::STARTUP_CYCLES - 1);

  eip_wstate_type                   state_r, state_nxt;
  logic [eip_pkg::WDT_CNT_W-1:0]    wdt_r;
  logic [eip_pkg::SUT_CNT_W-1:0]    sut_r;
  eip_pkg::eip_wake_type            evt_nxt;
  wire                              tick = (wdt_r == WDT_LAST);
  wire                              sut_end = (sut_r == SUT_LAST);

  // Watchdog oscillator stand-in: one tick per nominal period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wdt_r <= '0;
    else        wdt_r <= tick ? '0 : wdt_r + 5'h01;
  end

  // Level is seen on two successive ticks before wake
  always_comb begin
    state_nxt = state_r;
    evt_nxt   = '0;
    case (state_r)
      W_IDLE: begin
        if (sleep && tick && level_hit) state_nxt = W_SAMPLE1;
      end
      W_SAMPLE1: begin
        if (!sleep) begin
          state_nxt = W_IDLE;
        end else if (tick) begin
          state_nxt   = level_hit ? W_START : W_IDLE;
          evt_nxt.wake = level_hit;
        end
      end
      W_START: begin
        // Wake already given; the request only counts if level survives
        if (sut_end) begin
          state_nxt    = W_IDLE;
          evt_nxt.lost = !level_hit;
        end
      end
      default: state_nxt = W_IDLE;
    endcase
  end

  // Start-up timer runs only through the start-up phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= W_IDLE;
      sut_r   <= '0;
      evt     <= '0;
    end else begin
      state_r <= state_nxt;
      sut_r   <= (state_r == W_START) ? sut_r + 11'h001 : '0;
      evt     <= evt_nxt;
    end
  end

  assign starting = (state_r == W_START);
endmodule
